/* File: bench/flash_array_model.sv */
/* Flash array model behind the guard.
   Assumes writes arrive on the guard's clock. */
`timescale 1ns/1ns
module flash_array_model
	import flash_partition_guard_pkg::*;
(
	input wire logic            clk,
	input wire flash_write_type flash_wr
);
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	logic [15:0]            mem [0:2047];
	// starts erased, so a dropped write is told apart from an unknown
	initial begin
		for (int j = 0; j < 2048; j++)
			mem[j] = ERASED_WORD;
	end
	// changes only on a user-space write let through
	always @(posedge clk) begin
		if (flash_wr.valid && !flash_wr.cfg_space)
			mem[flash_wr.addr[10:0]] <= flash_wr.data;
	end
endmodule

/* File: bench/flash_partition_guard_sva.sv */
/* Checker for flash_partition_guard, bound below.
   Assumes straps change only while rst_n is low. */
`timescale 1ns/1ns
module flash_partition_guard_sva
	import flash_partition_guard_pkg::*;
#(parameter int unsigned FLASH_WORDS = 8192) (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire partition_cfg_type cfg_pins,
	input wire logic              config_region_write_protect,
	input wire fetch_req_type     fetch,
	input wire flash_write_type   wr_req,
	input wire flash_write_type   flash_wr,
	input wire logic              exec_violation_reset
);
	localparam int unsigned TOP = FLASH_WORDS - 128;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic       up;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// straps are caught some edges after release, so wait them out
	assign up = cnt == 4'h8;
	always_comb next_cnt = up ? cnt : cnt + 4'h1;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt <= 4'h0;
		else
			cnt <= next_cnt;
	end
	sequence s_app_wr;
		wr_req.valid && up && !wr_req.cfg_space && cfg_pins.boot_region_enable_n && wr_req.addr < TOP;
	endsequence
	AST_STORE_NOEXEC: assert property (
		fetch.valid && up && !cfg_pins.storage_area_enable_n && fetch.addr >= TOP && fetch.addr < FLASH_WORDS
		|=> exec_violation_reset) else $error("storage fetch ran");
	AST_LOW_EXEC: assert property (
		fetch.valid && up && fetch.addr < FLASH_WORDS && (fetch.addr < TOP || cfg_pins.storage_area_enable_n)
		|=> !exec_violation_reset) else $error("good fetch reset");
	AST_VIOL_CAUSE: assert property (
		exec_violation_reset |-> $past(fetch.valid)) else $error("reset without fetch");
	AST_WR_COPY: assert property (
		flash_wr.valid |-> $past(wr_req.valid) && flash_wr.addr == $past(wr_req.addr)
		&& flash_wr.data == $past(wr_req.data)) else $error("bad write copy");
	AST_CFG_WP: assert property (
		wr_req.valid && wr_req.cfg_space && config_region_write_protect |=> !flash_wr.valid)
		else $error("config write passed");
	AST_APP_WP: assert property (
		s_app_wr ##0 cfg_pins.app_region_write_protect |=> !flash_wr.valid) else $error("app write passed");
	AST_APP_OPEN: assert property (
		s_app_wr ##0 !cfg_pins.app_region_write_protect |=> flash_wr.valid) else $error("app write lost");
	AST_STORE_WR: assert property (
		wr_req.valid && up && !wr_req.cfg_space && !cfg_pins.storage_area_enable_n && wr_req.addr >= TOP
		&& wr_req.addr < FLASH_WORDS |=> flash_wr.valid) else $error("storage write lost");
endmodule

bind flash_partition_guard flash_partition_guard_sva #(.FLASH_WORDS(FLASH_WORDS)) sva_i (.clk(clk),
	.rst_n(rst_n), .cfg_pins(cfg_pins), .config_region_write_protect(config_region_write_protect),
	.fetch(fetch), .wr_req(wr_req), .flash_wr(flash_wr), .exec_violation_reset(exec_violation_reset));

/* File: bench/flash_partition_guard_tb.sv */
/* Bench for flash_partition_guard: APB master, fetch and write driver.
   Assumes the array model and checker are compiled alongside. */
`timescale 1ns/1ns
`include "flash_partition_guard_map.svh"
module flash_partition_guard_tb;
	import flash_partition_guard_pkg::*;
	localparam int unsigned FW = 1024;
	localparam int unsigned BU = 32;
	logic              clk, rst_n, cwp, irq, viol, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0]       paddr;
	logic [31:0]       pwdata, prdata, rd;
	partition_cfg_type cfg;
	fetch_req_type     fetch;
	flash_write_type   wr, fw, ws;
	logic [15:0]       a, old;
	int                mismatches, tests_run, i, k;
	flash_partition_guard #(.FLASH_WORDS(FW), .BOOT_UNIT_WORDS(BU)) flash_partition_guard_i (.clk(clk),
		.rst_n(rst_n), .cfg_pins(cfg), .config_region_write_protect(cwp), .fetch(fetch), .wr_req(wr),
		.flash_wr(fw), .exec_violation_reset(viol), .irq(irq), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	flash_array_model flash_array_model_i (.clk(clk), .flash_wr(fw));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic wr_ok(input logic [15:0] x, input logic cs);
		logic st, bt;
		st = !cfg.storage_area_enable_n && x >= FW - 128 && x < FW;
		bt = !cfg.boot_region_enable_n && x < (BU << cfg.boot_region_size);
		return cs ? !cwp : x < FW && (st || (bt ? !cfg.boot_region_write_protect : !cfg.app_region_write_protect));
	endfunction
	// one fetch and one write in the same cycle, both judged after
	task automatic op(input logic [15:0] x);
		ws = '{1'b1, 1'($urandom_range(7) == 0), x, 16'($urandom)};
		old = flash_array_model_i.mem[x[10:0]];
		@(posedge clk);
		fetch <= '{1'b1, x};
		wr <= ws;
		@(posedge clk);
		fetch <= '0;
		wr <= '0;
		@(posedge clk);
		chk(viol, x >= FW || (!cfg.storage_area_enable_n && x >= FW - 128));
		chk(fw.valid, wr_ok(x, ws.cfg_space));
		@(posedge clk);
		chk(flash_array_model_i.mem[x[10:0]], (!ws.cfg_space && wr_ok(x, 1'b0)) ? ws.data : old);
	endtask
	task automatic finish_test();
		$display("compared %0d, mismatched %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#300000;
		mismatches++;
		finish_test();
	end
	initial begin
		{rst_n, cwp, psel, penable, pwrite, paddr, pwdata} = '0;
		{cfg, fetch, wr} = '0;
		void'($urandom(32'h2A24));
		for (k = 0; k < 8; k++) begin
			rst_n <= 1'b0;
			cfg <= partition_cfg_type'({k[1], k[0], 5'($urandom)});
			cwp <= k[2];
			repeat (16) @(posedge clk);
			rst_n <= 1'b1;
			repeat (8) @(posedge clk);
			apb(1'b1, `FPG_OFS_CONFIG, 32'h0);
			apb(1'b0, `FPG_OFS_CONFIG, 32'h0);
			chk(rd[8:0], {1'b1, cwp, cfg});
			apb(1'b0, `FPG_OFS_CAUSE, 32'h0);
			chk(rd[0], 1'b1);
			apb(1'b1, `FPG_OFS_MASK, 32'h0);
			for (i = 0; i < 30; i++) begin
				a = i < 4 ? 16'(FW - 129 + (i == 1) + 128 * (i > 1) + (i == 3)) :
					i < 6 ? 16'((BU << cfg.boot_region_size) + i - 5) : 16'($urandom_range(FW + 63));
				op(a);
			end
			chk(irq, 1'b0);
			$display("config %0d done", k);
		end
		op(16'(FW + 5));
		apb(1'b1, `FPG_OFS_MASK, 32'h2);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		apb(1'b0, `FPG_OFS_STATUS, 32'h0);
		chk(rd[1:0], 2'b11);
		apb(1'b0, `FPG_OFS_CAUSE, 32'h0);
		chk(rd[0], 1'b0);
		chk(irq, 1'b0);
		apb(1'b0, `FPG_OFS_FAULT, 32'h0);
		chk(rd, 32'(FW + 5));
		apb(1'b0, 12'h014, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		$display("irq test done");
		finish_test();
	end
endmodule

/* File: src/flash_partition_guard.sv */
/*
 Flash partition guard: classifies flash addresses into application, boot
 and storage regions from straps caught after reset, checks fetches,
 filters writes toward the flash array, and offers an APB register file.
 Assumes fetch and write requests come from logic on clk; straps are
 static pins; config_region_write_protect is a static pin as well.
 A strap change after the catch has no effect until the next reset.
*/
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`include "flash_partition_guard_map.svh"

module flash_partition_guard
	import flash_partition_guard_pkg::*;
#(
	parameter int unsigned FLASH_WORDS     = 8192,
	parameter int unsigned BOOT_UNIT_WORDS = 512
) (
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	input  wire partition_cfg_type            cfg_pins,
	input  wire logic                         config_region_write_protect,
	input  wire fetch_req_type                fetch,
	input  wire flash_write_type              wr_req,
	output      flash_write_type              flash_wr,
	output      logic                         exec_violation_reset,
	output      logic                         irq,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [`FPG_APB_ADDR_W-1:0]   paddr,
	input  wire logic [31:0]                  pwdata,
	output      logic [31:0]                  prdata,
	output      logic                         pready,
	output      logic                         pslverr
);

	logic                       rst_meta_n;
	logic                       rst_sync_n;
	partition_cfg_type          cfg_meta;
	partition_cfg_type          cfg_sync;
	logic                       cfgwp_meta;
	logic                       cfgwp_sync;
	partition_cfg_type          cfg;
	logic                       cfgwp;
	logic                       cfg_loaded;
	partition_cfg_type          next_cfg;
	logic                       next_cfgwp;
	logic                       next_cfg_loaded;
	logic [1:0]                 fill;
	logic [1:0]                 next_fill;

	region_type                 fetch_region;
	region_type                 wr_region;
	logic                       fetch_bad;
	logic                       wr_prot;
	logic                       wr_bad;
	flash_write_type            next_flash_wr;
	logic                       next_exec_violation_reset;
	logic [`FPG_ADDR_W-1:0]     fault_addr;
	logic [`FPG_ADDR_W-1:0]     next_fault_addr;

	logic [`FPG_ST_W-1:0]       status;
	logic [`FPG_ST_W-1:0]       mask;
	logic                       exec_violation_flag;
	logic [`FPG_ST_W-1:0]       next_status;
	logic [`FPG_ST_W-1:0]       next_mask;
	logic                       next_exec_violation_flag;
	logic [31:0]                next_prdata;
	logic                       next_pready;
	logic                       next_pslverr;
	logic                       next_irq;
	logic                       apb_done;
	logic                       apb_wait;
	logic                       addr_hit;

	// reset release through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// straps pass two flops; caught once, when both stages hold pin values
	// catching earlier would freeze the flops' reset value, not the pins
	always_comb begin
		next_fill       = {fill[0], 1'b1};
		next_cfg        = cfg;
		next_cfgwp      = cfgwp;
		next_cfg_loaded = cfg_loaded || fill[1];
		if (!cfg_loaded && fill[1]) begin
			next_cfg   = cfg_sync;
			next_cfgwp = cfgwp_sync;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cfg_meta   <= `FPG_CFG_RESET;
			cfg_sync   <= `FPG_CFG_RESET;
			cfgwp_meta <= 1'b0;
			cfgwp_sync <= 1'b0;
			cfg        <= `FPG_CFG_RESET;
			cfgwp      <= 1'b0;
			cfg_loaded <= 1'b0;
			fill       <= 2'h0;
		end else begin
			cfg_meta   <= cfg_pins;
			cfg_sync   <= cfg_meta;
			cfgwp_meta <= config_region_write_protect;
			cfgwp_sync <= cfgwp_meta;
			cfg        <= next_cfg;
			cfgwp      <= next_cfgwp;
			cfg_loaded <= next_cfg_loaded;
			fill       <= next_fill;
		end
	end

	// one class per address; storage wins over boot at the top end
	function automatic region_type region_of(
		input logic [`FPG_ADDR_W-1:0] a,
		input partition_cfg_type      c
	);
		logic [31:0] wa;
		logic [31:0] boot_words;
		logic [31:0] storage_base;
		wa           = {{(32-`FPG_ADDR_W){1'b0}}, a};
		boot_words   = BOOT_UNIT_WORDS << c.boot_region_size;
		storage_base = FLASH_WORDS - `FPG_STORAGE_WORDS;
		if (wa >= FLASH_WORDS)
			region_of = REGION_NONE;
		else if (!c.storage_area_enable_n && wa >= storage_base)
			region_of = REGION_STORAGE;
		else if (!c.boot_region_enable_n && wa < boot_words)
			region_of = REGION_BOOT;
		else
			region_of = REGION_APP;
	endfunction

	// region of each request; no state of its own
	always_comb begin
		fetch_region = region_of(fetch.addr, cfg);
		wr_region    = region_of(wr_req.addr, cfg);
	end

	// fetch check; unchecked until the straps are caught
	always_comb begin
		fetch_bad                 = fetch.valid && cfg_loaded &&
			(fetch_region == REGION_STORAGE || fetch_region == REGION_NONE);
		next_exec_violation_reset = fetch_bad;
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			exec_violation_reset <= 1'b0;
		else
			exec_violation_reset <= next_exec_violation_reset;
	end

	// write filter toward the array
	always_comb begin
		if (wr_req.cfg_space)
			wr_prot = cfgwp;
		else begin
			case (wr_region)
				REGION_APP:     wr_prot = cfg.app_region_write_protect;
				REGION_BOOT:    wr_prot = cfg.boot_region_write_protect;
				REGION_STORAGE: wr_prot = 1'b0;
				REGION_NONE:    wr_prot = 1'b1;
				default:        wr_prot = 1'b1;
			endcase
		end
		// writes before the straps settle are refused, not guessed at
		wr_bad              = wr_req.valid && (wr_prot || !cfg_loaded);
		next_flash_wr       = wr_req;
		next_flash_wr.valid = wr_req.valid && !wr_bad;
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			flash_wr <= '0;
		else
			flash_wr <= next_flash_wr;
	end

	// last refused address; a bad fetch outranks a refused write
	always_comb begin
		next_fault_addr = fault_addr;
		if (fetch_bad)
			next_fault_addr = fetch.addr;
		else if (wr_bad)
			next_fault_addr = wr_req.addr;
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			fault_addr <= '0;
		else
			fault_addr <= next_fault_addr;
	end

	// apb slave: one wait cycle, answer registered
	always_comb begin
		apb_wait = psel && penable && !pready;
		apb_done = psel && penable && pready;
		addr_hit = (paddr == `FPG_OFS_CONFIG) || (paddr == `FPG_OFS_STATUS) ||
			(paddr == `FPG_OFS_MASK) || (paddr == `FPG_OFS_CAUSE) ||
			(paddr == `FPG_OFS_FAULT);
		next_pready  = apb_wait;
		next_pslverr = apb_wait && !addr_hit;
		next_prdata  = '0;
		if (apb_wait && !pwrite) begin
			case (paddr)
				`FPG_OFS_CONFIG: next_prdata = {{(32-`FPG_CFG_W-2){1'b0}}, cfg_loaded, cfgwp, cfg};
				`FPG_OFS_STATUS: next_prdata = {{(32-`FPG_ST_W){1'b0}}, status};
				`FPG_OFS_MASK:   next_prdata = {{(32-`FPG_ST_W){1'b0}}, mask};
				`FPG_OFS_CAUSE:  next_prdata = {31'h0000_0000, exec_violation_flag};
				`FPG_OFS_FAULT:  next_prdata = {{(32-`FPG_ADDR_W){1'b0}}, fault_addr};
				default:         next_prdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// mask: plain read-write
	always_comb begin
		next_mask = mask;
		if (apb_done && pwrite && paddr == `FPG_OFS_MASK)
			next_mask = pwdata[`FPG_ST_W-1:0];
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			mask <= '0;
		else
			mask <= next_mask;
	end

	// status: read clears; a new event in the same cycle survives
	always_comb begin
		next_status = status;
		if (apb_done && !pwrite && paddr == `FPG_OFS_STATUS)
			next_status = '0;
		if (wr_bad)
			next_status[`FPG_ST_WRITE_ERROR_FLAG] = 1'b1;
		if (fetch_bad)
			next_status[`FPG_ST_EXEC] = 1'b1;
		// irq follows the next values so it lands with the status bit
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			status <= '0;
			irq    <= 1'b0;
		end else begin
			status <= next_status;
			irq    <= next_irq;
		end
	end

	// software re-arms the flag; a violation clears it and wins
	always_comb begin
		next_exec_violation_flag = exec_violation_flag;
		if (apb_done && pwrite && paddr == `FPG_OFS_CAUSE)
			next_exec_violation_flag = pwdata[`FPG_CAUSE_EXEC];
		if (fetch_bad)
			next_exec_violation_flag = 1'b0;
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			exec_violation_flag <= `FPG_CAUSE_RESET;
		else
			exec_violation_flag <= next_exec_violation_flag;
	end

endmodule

/* File: src/flash_partition_guard_map.svh */
/*
 Constants of the flash partition guard: widths, register offsets,
 field positions and reset values. Included by the package and the top.
*/
`ifndef FLASH_PARTITION_GUARD_MAP_SVH
`define FLASH_PARTITION_GUARD_MAP_SVH

`define FPG_ADDR_W        16
`define FPG_DATA_W        16
`define FPG_APB_ADDR_W    12

`define FPG_OFS_CONFIG    12'h000
`define FPG_OFS_STATUS    12'h004
`define FPG_OFS_MASK      12'h008
`define FPG_OFS_CAUSE     12'h00C
`define FPG_OFS_FAULT     12'h010

`define FPG_ST_WRITE_ERROR_FLAG      0
`define FPG_ST_EXEC       1
`define FPG_ST_W          2

`define FPG_CAUSE_EXEC    0
`define FPG_CAUSE_RESET   1'b1

`define FPG_STORAGE_WORDS 32'h0000_0080
`define FPG_CFG_W         7
`define FPG_CFG_RESET     7'h60

`endif

/* File: src/flash_partition_guard_pkg.sv */
/*
 Types of the flash partition guard: configuration straps, fetch and
 write requests, region classes. Assumes the map header is on the path.
*/
`include "flash_partition_guard_map.svh"

package flash_partition_guard_pkg;

	typedef struct packed {
		logic       boot_region_enable_n;
		logic       storage_area_enable_n;
		logic [2:0] boot_region_size;
		logic       app_region_write_protect;
		logic       boot_region_write_protect;
	} partition_cfg_type;

	typedef struct packed {
		logic                    valid;
		logic [`FPG_ADDR_W-1:0]  addr;
	} fetch_req_type;

	typedef struct packed {
		logic                    valid;
		logic                    cfg_space;
		logic [`FPG_ADDR_W-1:0]  addr;
		logic [`FPG_DATA_W-1:0]  data;
	} flash_write_type;

	typedef enum logic [1:0] {
		REGION_APP,
		REGION_BOOT,
		REGION_STORAGE,
		REGION_NONE
	} region_type;

endpackage
